// ---- src/scps_params.svh ----
// constants for the status/control register and pin synchroniser block
// assumes an 8-bit register byte address and one 8-pin port
`ifndef SCPS_PARAMS_SVH
`define SCPS_PARAMS_SVH

`define SCPS_ADDR_W 8
`define SCPS_DATA_W 32
`define SCPS_NBITS 8
`define SCPS_NROUTE 16
`define SCPS_SEL_W 4
`define SCPS_NSUB 4
`define SCPS_NOE 4
`define SCPS_NPIN 8

`define SCPS_REG_CTRL 8'h00
`define SCPS_REG_STAT 8'h04
`define SCPS_REG_STAT_MODE 8'h08
`define SCPS_REG_STAT_SEL 8'h0c
`define SCPS_REG_CLK_CFG 8'h10
`define SCPS_REG_PIN_CFG 8'h14
`define SCPS_REG_IRQ_STAT 8'h18
`define SCPS_REG_IRQ_MASK 8'h1c

`define SCPS_CLK_FLD_W 4
`define SCPS_CLK_IDX_W 3
`define SCPS_CLK_USE_BIT 3

`define SCPS_OREG_LSB 0
`define SCPS_ISYNC_LSB 8
`define SCPS_OEMODE_LSB 16
`define SCPS_OEMODE_W 2

`define SCPS_RST_BYTE 8'h00
`define SCPS_RST_WORD 32'h0000_0000

`endif

// ---- src/scps_pkg.sv ----
// types shared by the status/control and pin synchroniser files
// assumes scps_params.svh is on the include path
`include "scps_params.svh"

package scps_pkg;

  typedef logic [`SCPS_NBITS-1:0] scps_byte_t;
  typedef logic [`SCPS_NROUTE-1:0] scps_route_t;

  // how the four routed output enables map onto the eight pins
  typedef enum logic [`SCPS_OEMODE_W-1:0] {
    SCPS_OE_GANG1,
    SCPS_OE_GANG2,
    SCPS_OE_GANG4,
    SCPS_OE_INDIV
  } scps_oe_mode_t;

endpackage

// ---- src/scps_stat_bit.sv ----
// one status bit: routing select, optional capture latch, clear on read
// assumes sources are on sys_clk and rd_clr is a one-cycle pulse
`timescale 1ns/1ps
`include "scps_params.svh"

module scps_stat_bit
  import scps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire scps_route_t src,
  input wire logic [`SCPS_SEL_W-1:0] sel,
  input wire logic capture,
  input wire logic sample_en,
  input wire logic rd_clr,
  output logic val,
  output logic evt
);

  logic cap_r;
  logic cap_nxt;
  logic picked;
  logic set;

  assign picked = src[sel];
  assign set = capture & sample_en & picked;
  // set wins over the read clear so a pulse in the read cycle survives
  assign cap_nxt = set | (cap_r & ~rd_clr);
  assign evt = set & ~cap_r;
  assign val = capture ? cap_r : picked;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cap_r <= 1'b0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

endmodule

// ---- src/scps_pin_io.sv ----
// one 8-pin port: optional output stage, optional input synchroniser,
// output-enable mapping; all stages on the master clock sys_clk
`timescale 1ns/1ps
`include "scps_params.svh"

module scps_pin_io
  import scps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire scps_byte_t dout,
  input wire logic [`SCPS_NOE-1:0] oe_grp,
  input wire scps_oe_mode_t oe_mode,
  input wire scps_byte_t oreg_en,
  input wire scps_byte_t isync_en,
  input wire scps_byte_t pin_in,
  output scps_byte_t pin_out,
  output scps_byte_t pin_oe_n,
  output scps_byte_t din
);

  function automatic logic oe_of(input scps_oe_mode_t m, input logic [`SCPS_NOE-1:0] g, input int i);
    logic r;
    r = 1'b0;
    case (m)
      SCPS_OE_GANG1: r = g[0];
      SCPS_OE_GANG2: r = g[i/4];
      SCPS_OE_GANG4: r = g[i/2];
      SCPS_OE_INDIV: r = (i < `SCPS_NOE) ? g[i] : 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  genvar i;
  generate
    for (i = 0; i < `SCPS_NPIN; i = i + 1) begin : g_pin
      logic oe_w;
      logic out_r;
      logic oe_r;
      logic s1_r;
      logic s2_r;

      assign oe_w = oe_of(oe_mode, oe_grp, i);

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          out_r <= 1'b0;
          oe_r <= 1'b0;
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          out_r <= dout[i];
          oe_r <= oe_w;
          s1_r <= pin_in[i];
          s2_r <= s1_r;
        end
      end

      // enable takes the same stage as data so the pin never glitches
      assign pin_out[i] = oreg_en[i] ? out_r : dout[i];
      assign pin_oe_n[i] = ~(oreg_en[i] ? oe_r : oe_w);
      // bypass is for pin-to-pin combinational paths only
      assign din[i] = isync_en[i] ? s2_r : pin_in[i];
    end
  endgenerate

endmodule

// ---- src/scps_top.sv ----
// status/control register bank of a programmable logic cell with the
// routed pin stage of one 8-pin port
// assumes a plain register port on sys_clk and routed logic on sys_clk
`timescale 1ns/1ps
`include "scps_params.svh"

module scps_top
  import scps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`SCPS_ADDR_W-1:0] reg_addr,
  input wire logic [`SCPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SCPS_DATA_W-1:0] reg_rdata,
  input wire scps_route_t route_stat,
  output scps_byte_t ctrl_route,
  output logic [`SCPS_NSUB-1:0] sub_clk_en,
  input wire scps_byte_t rt_pin_out,
  input wire logic [`SCPS_NOE-1:0] rt_pin_oe,
  output scps_byte_t rt_pin_in,
  input wire scps_byte_t pin_in,
  output scps_byte_t pin_out,
  output scps_byte_t pin_oe_n,
  output logic irq
);

  localparam int SEL_BITS = `SCPS_NBITS * `SCPS_SEL_W;
  localparam int CLK_BITS = `SCPS_NSUB * `SCPS_CLK_FLD_W;
  localparam int PIN_BITS = `SCPS_OEMODE_LSB + `SCPS_OEMODE_W;
  localparam int SUB_SELF = `SCPS_NSUB - 1;

  // register storage
  scps_byte_t ctrl_r;
  scps_byte_t ctrl_nxt;
  scps_byte_t stat_mode_r;
  scps_byte_t stat_mode_nxt;
  logic [SEL_BITS-1:0] stat_sel_r;
  logic [SEL_BITS-1:0] stat_sel_nxt;
  logic [CLK_BITS-1:0] clk_cfg_r;
  logic [CLK_BITS-1:0] clk_cfg_nxt;
  logic [PIN_BITS-1:0] pin_cfg_r;
  logic [PIN_BITS-1:0] pin_cfg_nxt;
  scps_byte_t irq_stat_r;
  scps_byte_t irq_stat_nxt;
  scps_byte_t irq_mask_r;
  scps_byte_t irq_mask_nxt;
  logic [`SCPS_DATA_W-1:0] rdata_r;
  logic [`SCPS_DATA_W-1:0] rdata_nxt;
  logic [`SCPS_NSUB-1:0] clk_en_r;
  logic [`SCPS_NSUB-1:0] clk_en_nxt;
  logic irq_r;
  logic irq_nxt;

  // address decode, shared by write and read paths
  function automatic logic hit(input logic [`SCPS_ADDR_W-1:0] a, input logic [`SCPS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  logic wr_ctrl;
  logic wr_mode;
  logic wr_sel;
  logic wr_clk;
  logic wr_pin;
  logic wr_istat;
  logic wr_imask;
  logic rd_stat;

  assign wr_ctrl = reg_wr & hit(reg_addr, `SCPS_REG_CTRL);
  assign wr_mode = reg_wr & hit(reg_addr, `SCPS_REG_STAT_MODE);
  assign wr_sel = reg_wr & hit(reg_addr, `SCPS_REG_STAT_SEL);
  assign wr_clk = reg_wr & hit(reg_addr, `SCPS_REG_CLK_CFG);
  assign wr_pin = reg_wr & hit(reg_addr, `SCPS_REG_PIN_CFG);
  assign wr_istat = reg_wr & hit(reg_addr, `SCPS_REG_IRQ_STAT);
  assign wr_imask = reg_wr & hit(reg_addr, `SCPS_REG_IRQ_MASK);
  // a write to the status offset is ignored: the register is read-only
  assign rd_stat = reg_rd & hit(reg_addr, `SCPS_REG_STAT);

  assign ctrl_nxt = wr_ctrl ? reg_wdata[`SCPS_NBITS-1:0] : ctrl_r;
  assign stat_mode_nxt = wr_mode ? reg_wdata[`SCPS_NBITS-1:0] : stat_mode_r;
  assign stat_sel_nxt = wr_sel ? reg_wdata[SEL_BITS-1:0] : stat_sel_r;
  assign clk_cfg_nxt = wr_clk ? reg_wdata[CLK_BITS-1:0] : clk_cfg_r;
  assign pin_cfg_nxt = wr_pin ? reg_wdata[PIN_BITS-1:0] : pin_cfg_r;
  assign irq_mask_nxt = wr_imask ? reg_wdata[`SCPS_NBITS-1:0] : irq_mask_r;

  // clock enables: each sub-block picks a control bit or runs freely
  logic [`SCPS_NSUB-1:0] en_w;
  genvar s;
  generate
    for (s = 0; s < `SCPS_NSUB; s = s + 1) begin : g_sub
      logic [`SCPS_CLK_FLD_W-1:0] fld;
      logic [`SCPS_CLK_IDX_W-1:0] idx;
      logic use_ctrl;
      assign fld = clk_cfg_r[s*`SCPS_CLK_FLD_W +: `SCPS_CLK_FLD_W];
      assign idx = fld[`SCPS_CLK_IDX_W-1:0];
      assign use_ctrl = fld[`SCPS_CLK_USE_BIT];
      assign en_w[s] = use_ctrl ? ctrl_r[idx] : 1'b1;
    end
  endgenerate

  assign clk_en_nxt = en_w;

  // status bits
  scps_byte_t stat_val;
  scps_byte_t stat_evt;
  logic self_en;

  // status capture obeys the status/control block's own selected enable; register writes and direct status bits do not
  assign self_en = clk_en_r[SUB_SELF];

  genvar b;
  generate
    for (b = 0; b < `SCPS_NBITS; b = b + 1) begin : g_stat
      scps_stat_bit u_bit (
        .sys_clk(sys_clk),
        .srst(srst),
        .src(route_stat),
        .sel(stat_sel_r[b*`SCPS_SEL_W +: `SCPS_SEL_W]),
        .capture(stat_mode_r[b]),
        .sample_en(self_en),
        .rd_clr(rd_stat),
        .val(stat_val[b]),
        .evt(stat_evt[b])
      );
    end
  endgenerate

  // interrupt status: write one to clear, a new event in the same cycle wins
  scps_byte_t istat_clr;
  assign istat_clr = wr_istat ? reg_wdata[`SCPS_NBITS-1:0] : `SCPS_RST_BYTE;
  assign irq_stat_nxt = stat_evt | (irq_stat_r & ~istat_clr);
  assign irq_nxt = |(irq_stat_nxt & irq_mask_r);

  // read mux; unmapped offsets answer zero
  logic [`SCPS_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = `SCPS_RST_WORD;
    case (reg_addr)
      `SCPS_REG_CTRL: rd_mux[`SCPS_NBITS-1:0] = ctrl_r;
      `SCPS_REG_STAT: rd_mux[`SCPS_NBITS-1:0] = stat_val;
      `SCPS_REG_STAT_MODE: rd_mux[`SCPS_NBITS-1:0] = stat_mode_r;
      `SCPS_REG_STAT_SEL: rd_mux[SEL_BITS-1:0] = stat_sel_r;
      `SCPS_REG_CLK_CFG: rd_mux[CLK_BITS-1:0] = clk_cfg_r;
      `SCPS_REG_PIN_CFG: rd_mux[PIN_BITS-1:0] = pin_cfg_r;
      `SCPS_REG_IRQ_STAT: rd_mux[`SCPS_NBITS-1:0] = irq_stat_r;
      `SCPS_REG_IRQ_MASK: rd_mux[`SCPS_NBITS-1:0] = irq_mask_r;
      default: rd_mux = `SCPS_RST_WORD;
    endcase
  end

  // data stands only in the cycle after the strobe
  assign rdata_nxt = reg_rd ? rd_mux : `SCPS_RST_WORD;

  // one short process per register; every one clears on srst
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= `SCPS_RST_BYTE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // capture selects, one bit per status bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stat_mode_r <= `SCPS_RST_BYTE;
    end else begin
      stat_mode_r <= stat_mode_nxt;
    end
  end

  // four select bits per status bit into the routed sources
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stat_sel_r <= '0;
    end else begin
      stat_sel_r <= stat_sel_nxt;
    end
  end

  // cleared config means every sub-block runs freely after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_cfg_r <= '0;
    end else begin
      clk_cfg_r <= clk_cfg_nxt;
    end
  end

  // cleared config leaves all pins in bypass and ganged on one enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_cfg_r <= '0;
    end else begin
      pin_cfg_r <= pin_cfg_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_stat_r <= `SCPS_RST_BYTE;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask_r <= `SCPS_RST_BYTE;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= `SCPS_RST_WORD;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // enables are registered so a control write reaches them one cycle later
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_en_r <= '0;
    end else begin
      clk_en_r <= clk_en_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ctrl_route = ctrl_r;
  assign sub_clk_en = clk_en_r;
  assign irq = irq_r;

  // pin side: 8 data out, 8 data in and 4 enables per port
  scps_oe_mode_t oe_mode;
  assign oe_mode = scps_oe_mode_t'(pin_cfg_r[`SCPS_OEMODE_LSB +: `SCPS_OEMODE_W]);

  scps_pin_io u_pins (
    .sys_clk(sys_clk),
    .srst(srst),
    .dout(rt_pin_out),
    .oe_grp(rt_pin_oe),
    .oe_mode(oe_mode),
    .oreg_en(pin_cfg_r[`SCPS_OREG_LSB +: `SCPS_NPIN]),
    .isync_en(pin_cfg_r[`SCPS_ISYNC_LSB +: `SCPS_NPIN]),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .din(rt_pin_in)
  );

endmodule

// ---- testbench/scps_monitor.sv ----
// port-level checks for the status/control and pin block
// assumes it is bound to scps_top and sees only its ports
`timescale 1ns/1ps
`include "scps_params.svh"

module scps_monitor
  import scps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [`SCPS_ADDR_W-1:0] reg_addr,
  input wire logic [`SCPS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SCPS_DATA_W-1:0] reg_rdata,
  input wire scps_route_t route_stat,
  input wire scps_byte_t ctrl_route,
  input wire logic [`SCPS_NSUB-1:0] sub_clk_en,
  input wire scps_byte_t rt_pin_out,
  input wire logic [`SCPS_NOE-1:0] rt_pin_oe,
  input wire scps_byte_t rt_pin_in,
  input wire scps_byte_t pin_in,
  input wire scps_byte_t pin_out,
  input wire scps_byte_t pin_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its slot");
  a_ctrl_write: assert property (reg_wr && reg_addr == `SCPS_REG_CTRL |=> ctrl_route == $past(reg_wdata[7:0]))
    else $error("control write not applied");
  a_ctrl_hold: assert property (!(reg_wr && reg_addr == `SCPS_REG_CTRL) |=> $stable(ctrl_route))
    else $error("control bits changed without a write");
  a_reset_clear: assert property ($fell(srst) |-> ctrl_route == 8'h00 && !irq &&
    pin_oe_n == {8{~rt_pin_oe[0]}})
    else $error("state not cleared by reset");
  a_rd_ctrl: assert property (reg_rd && reg_addr == `SCPS_REG_CTRL |=> reg_rdata == {24'h00_0000, $past(ctrl_route)})
    else $error("control readback wrong");
  a_rd_unmapped: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stat_width: assert property (reg_rd && reg_addr == `SCPS_REG_STAT |=> reg_rdata[31:8] == 24'h00_0000)
    else $error("status upper bits not zero");
  a_irq_masked: assert property (reg_wr && reg_addr == `SCPS_REG_IRQ_MASK && reg_wdata[7:0] == 8'h00 |-> ##2 !irq)
    else $error("masked interrupt still high");

  c_irq_rise: cover property ($rose(irq));
  c_stat_read: cover property (reg_rd && reg_addr == `SCPS_REG_STAT);
  c_oe_split: cover property (pin_oe_n == 8'hc3);
endmodule

bind scps_top scps_monitor mon(.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_stat(route_stat), .ctrl_route(ctrl_route),
  .sub_clk_en(sub_clk_en), .rt_pin_out(rt_pin_out), .rt_pin_oe(rt_pin_oe), .rt_pin_in(rt_pin_in),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

// ---- testbench/scps_pad_model.sv ----
// pad model of one 8-pin port with an outside driver
// assumes active-low per-pin output enables from the block
`timescale 1ns/1ps

module scps_pad_model
  import scps_pkg::*;
(
  input wire scps_byte_t pin_out,
  input wire scps_byte_t pin_oe_n,
  input wire scps_byte_t ext,
  output scps_byte_t pin_in
);
  // a released pin shows the outside driver, never the last driven value
  assign pin_in = (ext & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for scps_top with a pad model on its port
// assumes the plain register port and one clock
`timescale 1ns/1ps
`include "scps_params.svh"

module testbench;
  import scps_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  scps_route_t route_stat = 16'h0000;
  scps_byte_t rt_pin_out = 8'h00;
  scps_byte_t ext = 8'h5a;
  scps_byte_t ctrl_route, rt_pin_in, pin_in, pin_out, pin_oe_n;
  logic [3:0] rt_pin_oe = 4'h0;
  logic [3:0] sub_clk_en;
  logic irq;
  int err_total = 0;
  int compares = 0;

  always #2.5 sys_clk = ~sys_clk;

  scps_top dut(.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_stat(route_stat), .ctrl_route(ctrl_route),
    .sub_clk_en(sub_clk_en), .rt_pin_out(rt_pin_out), .rt_pin_oe(rt_pin_oe), .rt_pin_in(rt_pin_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  scps_pad_model pad(.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext), .pin_in(pin_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic scps_byte_t oe_exp(input int m, input logic [3:0] oe);
    scps_byte_t r;
    for (int i = 0; i < 8; i++)
      r[i] = ~(m == 0 ? oe[0] : m == 1 ? oe[i / 4] : m == 2 ? oe[i / 2] : (i < 4 && oe[i]));
    return r;
  endfunction

  task automatic t_ctrl;
    wr(`SCPS_REG_CTRL, 32'hffff_ffa5);
    #1;
    chk(32'(ctrl_route), 32'h0000_00a5);
    wr(`SCPS_REG_STAT, 32'h0000_00ff);
    wr(8'h20, 32'h0000_00ff);
    rdc(`SCPS_REG_CTRL, 32'h0000_00a5);
    rdc(8'h20, 32'h0000_0000);
  endtask

  task automatic t_stat;
    wr(`SCPS_REG_STAT_SEL, 32'h89ab_cdef);
    route_stat <= 16'h1e81;
    rdc(`SCPS_REG_STAT, 32'h0000_0078);
  endtask

  task automatic t_capture;
    @(posedge sys_clk);
    route_stat <= 16'h0000;
    wr(`SCPS_REG_STAT_SEL, 32'h0000_0000);
    wr(`SCPS_REG_STAT_MODE, 32'h0000_0001);
    wr(`SCPS_REG_IRQ_MASK, 32'h0000_0001);
    @(posedge sys_clk);
    route_stat <= 16'h0001;
    @(posedge sys_clk);
    route_stat <= 16'h0000;
    step(2);
    chk(32'(irq), 32'h0000_0001);
    rdc(`SCPS_REG_STAT, 32'h0000_0001);
    rdc(`SCPS_REG_STAT, 32'h0000_0000);
    wr(`SCPS_REG_IRQ_STAT, 32'h0000_0001);
    step(1);
    chk(32'(irq), 32'h0000_0000);
    wr(`SCPS_REG_IRQ_MASK, 32'h0000_0000);
    @(posedge sys_clk);
    route_stat <= 16'h0001;
    @(posedge sys_clk);
    route_stat <= 16'h0000;
    step(2);
    chk(32'(irq), 32'h0000_0000);
    rdc(`SCPS_REG_STAT, 32'h0000_0001);
  endtask

  // sub-block 0 follows control bit 2, the others stay always enabled
  task automatic t_clk;
    wr(`SCPS_REG_CLK_CFG, 32'h0000_000a);
    wr(`SCPS_REG_CTRL, 32'h0000_0000);
    step(2);
    chk(32'(sub_clk_en), 32'h0000_000e);
    wr(`SCPS_REG_CTRL, 32'h0000_0004);
    step(2);
    chk(32'(sub_clk_en), 32'h0000_000f);
  endtask

  // the status block follows control bit 0: no capture while it is low
  task automatic t_gate;
    wr(`SCPS_REG_CLK_CFG, 32'h0000_8000);
    step(1);
    chk(32'(sub_clk_en), 32'h0000_0007);
    @(posedge sys_clk);
    route_stat <= 16'h0001;
    @(posedge sys_clk);
    route_stat <= 16'h0000;
    rdc(`SCPS_REG_STAT, 32'h0000_0000);
    wr(`SCPS_REG_CTRL, 32'h0000_0001);
    step(1);
    @(posedge sys_clk);
    route_stat <= 16'h0001;
    @(posedge sys_clk);
    route_stat <= 16'h0000;
    rdc(`SCPS_REG_STAT, 32'h0000_0001);
    wr(`SCPS_REG_CLK_CFG, 32'h0000_0000);
  endtask

  task automatic t_pins;
    @(posedge sys_clk);
    rt_pin_oe <= 4'b0110;
    rt_pin_out <= 8'h3c;
    for (int m = 0; m < 4; m++) begin
      wr(`SCPS_REG_PIN_CFG, 32'(m) << 16);
      step(1);
      chk(32'(pin_oe_n), 32'(oe_exp(m, 4'b0110)));
    end
    chk(32'(rt_pin_in), 32'h0000_005c);
    @(posedge sys_clk);
    rt_pin_oe <= 4'h0;
    wr(`SCPS_REG_PIN_CFG, 32'h0003_ffff);
    step(3);
    @(posedge sys_clk);
    rt_pin_out <= 8'hc3;
    rt_pin_oe <= 4'h1;
    ext <= 8'ha5;
    #1;
    chk(32'(pin_out), 32'h0000_003c);
    chk(32'(pin_oe_n), 32'h0000_00ff);
    step(1);
    chk(32'(pin_out), 32'h0000_00c3);
    chk(32'(pin_oe_n), 32'h0000_00fe);
    chk(32'(rt_pin_in), 32'h0000_005a);
    step(1);
    chk(32'(rt_pin_in), 32'h0000_00a5);
  endtask

  task automatic end_sim;
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rdc(`SCPS_REG_CTRL, 32'h0000_0000);
    rdc(`SCPS_REG_PIN_CFG, 32'h0000_0000);
    chk(32'(pin_oe_n), 32'h0000_00ff);
    chk(32'(sub_clk_en), 32'h0000_000f);
    t_ctrl;
    t_stat;
    t_capture;
    t_clk;
    t_gate;
    t_pins;
    end_sim;
  end

  initial begin
    #20000;
    err_total++;
    end_sim;
  end
endmodule
